// [inc/adcc_pkg.sv]
package adcc_pkg;
	// byte addresses of the dword words that hold the registers
	localparam logic [7:0] ADDR_INDEX_WORD = 8'h04;
	localparam logic [7:0] ADDR_POSITION_WORD = 8'h08;
	localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'h2C;
	localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h30;
	// byte lanes inside those words
	localparam int LANE_LAST_INDEX = 1;
	localparam int LANE_STATUS = 2;
	localparam int LANE_CONTROL = 3;
	localparam logic [4:0] INDEX_STEP = 5'h01;
	localparam logic [15:0] POSITION_STEP = 16'h0001;
	localparam logic [2:0] DESC_SHIFT_PAD = 3'h0;
	localparam logic [31:0] GCTL_RESET = 32'h0000_0000;
	localparam logic [31:0] GCTL_WRITE_MASK = 32'hC0F0_007F;
	localparam logic [6:0] GCTL_KEPT_RESET = 7'h00;
	// global status bit positions
	localparam int GSTA_GPI_CHANGE = 0;
	localparam int GSTA_RESUME_0 = 10;
	localparam int GSTA_RESUME_1 = 11;
	localparam int GSTA_CLOCK_STOPPED = 27;
	localparam int GSTA_RESUME_2 = 29;
	// link timing, in host clocks and bit clocks
	localparam logic [2:0] CLOCK_STOP_CLOCKS = 3'h4;
	localparam logic [7:0] LINK_SYNC_BITS = 8'h10;
	localparam logic [7:0] LINK_RX_BITS = 8'h15;
	localparam int SAMPLE_BITS = 20;
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_20 = 2'h1;

	typedef enum logic [1:0] {st_idle, st_fetch, st_xfer, st_last} adcc_state_type;

	typedef struct packed {
		logic fifo_error_flag;
		logic buffer_done_status;
		logic last_buffer_event;
		logic index_at_last_state;
		logic engine_halted;
	} adcc_status_type;
	localparam adcc_status_type STATUS_RESET = 5'h01;

	typedef struct packed {
		logic [2:0] reserved;
		logic completion_irq_enable;
		logic fifo_error_irq_enable;
		logic last_buffer_irq_enable;
		logic channel_register_reset;
		logic run_pause_control;
	} adcc_control_type;
	localparam adcc_control_type CONTROL_RESET = 8'h00;

	typedef struct packed {
		logic [1:0] digital_out_slot_select;
		logic [5:0] reserved_hi;
		logic [1:0] output_sample_width;
		logic [1:0] output_channel_count;
		logic [12:0] reserved_lo;
		logic [2:0] resume_irq_enable;
		logic link_outputs_off;
		logic warm_reset;
		logic cold_reset_n;
		logic gpin_change_irq_enable;
	} adcc_gctl_type;
endpackage : adcc_pkg

// [rtl/adcc_channel_control.sv]
// Summary of operation
// - overrun: keep pointers, drop sample, flag error
// - underrun: flag error, resend last sample
// - error flag only while buffers remain
// - completion bit on flagged buffer end, W1C
// - last-buffer event: fetch (tx), write (rx)
// - index-at-last state, cleared by new last index
// - halted when paused idle or last done
// - 16-bit count of samples left in memory
// - prefetched index, modulo 32
// - three enables gate channel interrupt sources
// - channel reset keeps enables, self-clears
// - run starts, pause keeps all state
// - slot pair for digital output while running
// - output sample width 16 or 20 bits
// - output channel count two, four, six
// - per-line resume interrupt enables
// - link shut off drives outputs low
// - warm reset only while clock stopped
// - active-low cold reset, defaults asserted
// - gpin change sets status, gated interrupt
// - global control 6:0 survive hot return
// - current index increments, wraps after 31
// - descriptors eight bytes, 32 entries
`timescale 1ns/1ps
`default_nettype none
module adcc_channel_control (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic hot_return_rst,
	// register port
	input wire logic [7:0] io_addr,
	input wire logic [3:0] io_be,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [31:0] io_wdata,
	output logic [31:0] io_rdata,
	// channel direction
	input wire logic channel_is_transmit,
	// descriptor fetch
	output logic desc_req,
	output logic [7:0] desc_offset,
	input wire logic desc_ack,
	input wire logic [15:0] desc_len,
	input wire logic descriptor_completion_flag,
	// sample memory
	output logic mem_req,
	output logic mem_write,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// serial link
	input wire logic bit_clk,
	input wire logic serial_in_line_0,
	input wire logic serial_in_line_1,
	input wire logic serial_in_line_2,
	output logic link_sync,
	output logic link_sdata_out,
	output logic link_reset_n,
	output logic link_outputs_oe,
	// interrupts and mode outputs
	output logic chan_irq,
	output logic global_irq,
	output logic [3:0] digital_out_slot_a,
	output logic [3:0] digital_out_slot_b,
	output logic [1:0] output_sample_width,
	output logic [1:0] output_channel_count
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] word);
		hit = a[7:2] == word[7:2];
	endfunction : hit

	function automatic logic [7:0] slot_pair(input logic [1:0] sel);
		unique case (sel)
			2'h1: slot_pair = 8'h78;
			2'h2: slot_pair = 8'h69;
			2'h3: slot_pair = 8'hAB;
			2'h0: slot_pair = 8'h00;
		endcase
	endfunction : slot_pair

	// ---- pin synchronisers: three stages, change taken when stages 2 and 3 agree
	logic [3:0] pin_raw;
	logic [2:0] pin_s_q [4];
	logic [3:0] pin_f_q, pin_f_d, pin_rise, pin_fall;
	assign pin_raw = {serial_in_line_2, serial_in_line_1, serial_in_line_0, bit_clk};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_pin
			always_comb
			begin
				pin_f_d[gi] = (pin_s_q[gi][1] == pin_s_q[gi][2]) ? pin_s_q[gi][2] : pin_f_q[gi];
				pin_rise[gi] = pin_f_d[gi] & ~pin_f_q[gi];
				pin_fall[gi] = ~pin_f_d[gi] & pin_f_q[gi];
			end
			always_ff @(posedge clock)
			begin
				if (rst)
				begin
					pin_s_q[gi] <= 3'h0;
					pin_f_q[gi] <= 1'b0;
				end
				else
				begin
					pin_s_q[gi] <= {pin_s_q[gi][1:0], pin_raw[gi]};
					pin_f_q[gi] <= pin_f_d[gi];
				end
			end
		end
	endgenerate

	// ---- link side state
	logic [2:0] idle_cnt_q, idle_cnt_d;
	logic [7:0] bit_cnt_q, bit_cnt_d;
	logic [adcc_pkg::SAMPLE_BITS-1:0] tx_shift_q, tx_shift_d, tx_word;
	logic [adcc_pkg::SAMPLE_BITS:0] rx_shift_q, rx_shift_d, rx_word;
	logic clock_stopped, tx_take, rx_done, sin_or;
	logic link_sync_d, link_sdata_d, link_reset_n_d, link_oe_d;
	adcc_pkg::adcc_gctl_type gctl_q, gctl_d;

	always_comb
	begin
		clock_stopped = idle_cnt_q >= adcc_pkg::CLOCK_STOP_CLOCKS;
		idle_cnt_d = (pin_rise[0] | pin_fall[0]) ? 3'h0 : (clock_stopped ? idle_cnt_q : idle_cnt_q + 3'h1);
		sin_or = |pin_f_q[3:1];
		bit_cnt_d = bit_cnt_q;
		tx_shift_d = tx_shift_q;
		rx_shift_d = rx_shift_q;
		tx_take = pin_rise[0] && bit_cnt_q == 8'h00;
		rx_done = pin_fall[0] && bit_cnt_q == adcc_pkg::LINK_RX_BITS;
		rx_word = {rx_shift_q[adcc_pkg::SAMPLE_BITS-1:0], sin_or};
		// the 8-bit count wraps by itself, giving 256 bit clocks to a frame
		if (pin_rise[0])
		begin
			bit_cnt_d = bit_cnt_q + 8'h01;
			tx_shift_d = tx_take ? tx_word : {tx_shift_q[adcc_pkg::SAMPLE_BITS-2:0], 1'b0};
		end
		if (pin_fall[0])
			rx_shift_d = rx_word;
		link_oe_d = ~gctl_q.link_outputs_off;
		link_sync_d = link_oe_d & (gctl_q.warm_reset | (~clock_stopped && bit_cnt_q < adcc_pkg::LINK_SYNC_BITS));
		link_sdata_d = link_oe_d & tx_shift_q[adcc_pkg::SAMPLE_BITS-1];
		link_reset_n_d = link_oe_d & gctl_q.cold_reset_n;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			idle_cnt_q <= 3'h0;
			bit_cnt_q <= 8'h00;
			tx_shift_q <= '0;
			rx_shift_q <= '0;
			link_sync <= 1'b0;
			link_sdata_out <= 1'b0;
			link_reset_n <= 1'b0;
			link_outputs_oe <= 1'b0;
		end
		else
		begin
			idle_cnt_q <= idle_cnt_d;
			bit_cnt_q <= bit_cnt_d;
			tx_shift_q <= tx_shift_d;
			rx_shift_q <= rx_shift_d;
			link_sync <= link_sync_d;
			link_sdata_out <= link_sdata_d;
			link_reset_n <= link_reset_n_d;
			link_outputs_oe <= link_oe_d;
		end
	end

	// ---- channel engine and registers
	adcc_pkg::adcc_state_type state_q, state_d;
	adcc_pkg::adcc_status_type stat_q, stat_d;
	adcc_pkg::adcc_control_type ctl_q, ctl_d;
	logic [4:0] civ_q, civ_d, lvi_q, lvi_d, piv_q, piv_d;
	logic [15:0] pos_q, pos_d;
	logic ioc_q, ioc_d, hold_full_q, hold_full_d, desc_req_d, mem_req_d;
	logic [adcc_pkg::SAMPLE_BITS-1:0] hold_q, hold_d, last_q, last_d;
	logic [31:0] gsta_q, gsta_d, rdata_d, wmask;
	logic fe_set, bd_set, lvb_set, lvi_wr, ctl_wr, chan_irq_d, global_irq_d;
	logic [7:0] slots_d;

	always_comb
	begin
		state_d = state_q;
		stat_d = stat_q;
		ctl_d = ctl_q;
		civ_d = civ_q;
		lvi_d = lvi_q;
		piv_d = piv_q;
		pos_d = pos_q;
		ioc_d = ioc_q;
		hold_d = hold_q;
		hold_full_d = hold_full_q;
		last_d = last_q;
		desc_req_d = desc_req;
		mem_req_d = mem_req;
		fe_set = 1'b0;
		bd_set = 1'b0;
		lvb_set = 1'b0;
		lvi_wr = io_wr && hit(io_addr, adcc_pkg::ADDR_INDEX_WORD) && io_be[adcc_pkg::LANE_LAST_INDEX];
		ctl_wr = io_wr && hit(io_addr, adcc_pkg::ADDR_POSITION_WORD) && io_be[adcc_pkg::LANE_CONTROL];
		// repeat the last good sample when nothing is held
		tx_word = hold_full_q ? hold_q : last_q;
		if (tx_take && channel_is_transmit && ctl_q.run_pause_control)
		begin
			if (hold_full_q)
			begin
				hold_full_d = 1'b0;
				last_d = hold_q;
			end
			else
				fe_set = ~stat_q.index_at_last_state;
		end
		if (rx_done && !channel_is_transmit && ctl_q.run_pause_control)
		begin
			if (hold_full_q)
				fe_set = ~stat_q.index_at_last_state;
			else
			begin
				hold_d = rx_word[adcc_pkg::SAMPLE_BITS:1];
				hold_full_d = 1'b1;
			end
		end
		if (mem_ack && mem_req)
		begin
			mem_req_d = 1'b0;
			pos_d = pos_q - adcc_pkg::POSITION_STEP;
			hold_full_d = channel_is_transmit;
			if (channel_is_transmit)
				hold_d = (gctl_q.output_sample_width == adcc_pkg::WIDTH_20) ? mem_rdata[31:12] : {mem_rdata[15:0], 4'h0};
		end
		else if (state_q == adcc_pkg::st_xfer && pos_q != 16'h0000 && ctl_q.run_pause_control && !mem_req
			&& hold_full_q != channel_is_transmit)
			mem_req_d = 1'b1;
		unique case (state_q)
			adcc_pkg::st_idle:
				if (ctl_q.run_pause_control)
				begin
					desc_req_d = 1'b1;
					state_d = adcc_pkg::st_fetch;
				end
			adcc_pkg::st_fetch:
				if (desc_ack)
				begin
					desc_req_d = 1'b0;
					pos_d = desc_len;
					ioc_d = descriptor_completion_flag;
					piv_d = civ_q;
					lvb_set = channel_is_transmit && civ_q == lvi_q;
					state_d = adcc_pkg::st_xfer;
				end
			adcc_pkg::st_xfer:
				if (pos_q == 16'h0000 && !mem_req)
				begin
					bd_set = ioc_q;
					if (civ_q == lvi_q)
					begin
						stat_d.index_at_last_state = 1'b1;
						lvb_set = !channel_is_transmit;
						state_d = adcc_pkg::st_last;
					end
					else
					begin
						civ_d = civ_q + adcc_pkg::INDEX_STEP;
						state_d = adcc_pkg::st_idle;
					end
				end
			adcc_pkg::st_last:
				if (lvi_wr)
				begin
					stat_d.index_at_last_state = 1'b0;
					civ_d = civ_q + adcc_pkg::INDEX_STEP;
					state_d = adcc_pkg::st_idle;
				end
		endcase
		if (lvi_wr)
			lvi_d = io_wdata[12:8];
		if (ctl_wr)
		begin
			ctl_d = io_wdata[31:24];
			ctl_d.reserved = 3'h0;
			ctl_d.channel_register_reset = 1'b0;
		end
		// write-one-to-clear, a same-cycle set wins
		wmask = (io_wr && hit(io_addr, adcc_pkg::ADDR_INDEX_WORD) && io_be[adcc_pkg::LANE_STATUS]) ? io_wdata : 32'h0;
		stat_d.fifo_error_flag = fe_set | (stat_q.fifo_error_flag & ~wmask[20]);
		stat_d.buffer_done_status = bd_set | (stat_q.buffer_done_status & ~wmask[19]);
		stat_d.last_buffer_event = lvb_set | (stat_q.last_buffer_event & ~wmask[18]);
		stat_d.engine_halted = stat_d.index_at_last_state
			| (~ctl_d.run_pause_control & ~mem_req_d & ~desc_req_d);
		// undefined while running, so no guard against a busy engine
		if (ctl_wr && io_wdata[25])
		begin
			state_d = adcc_pkg::st_idle;
			stat_d = adcc_pkg::STATUS_RESET;
			ctl_d.run_pause_control = 1'b0;
			civ_d = 5'h00;
			lvi_d = 5'h00;
			piv_d = 5'h00;
			pos_d = 16'h0000;
			ioc_d = 1'b0;
			hold_full_d = 1'b0;
			desc_req_d = 1'b0;
			mem_req_d = 1'b0;
		end
		chan_irq_d = |({stat_q.buffer_done_status, stat_q.fifo_error_flag, stat_q.last_buffer_event}
			& {ctl_q.completion_irq_enable, ctl_q.fifo_error_irq_enable, ctl_q.last_buffer_irq_enable});
		slots_d = ctl_q.run_pause_control ? slot_pair(gctl_q.digital_out_slot_select) : 8'h00;
	end

	always_ff @(posedge clock)
	begin
		if (rst || hot_return_rst)
		begin
			state_q <= adcc_pkg::st_idle;
			stat_q <= adcc_pkg::STATUS_RESET;
			ctl_q <= adcc_pkg::CONTROL_RESET;
			civ_q <= 5'h00;
			lvi_q <= 5'h00;
			piv_q <= 5'h00;
			pos_q <= 16'h0000;
			ioc_q <= 1'b0;
			hold_q <= '0;
			hold_full_q <= 1'b0;
			last_q <= '0;
			desc_req <= 1'b0;
			mem_req <= 1'b0;
			chan_irq <= 1'b0;
			digital_out_slot_a <= 4'h0;
			digital_out_slot_b <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			stat_q <= stat_d;
			ctl_q <= ctl_d;
			civ_q <= civ_d;
			lvi_q <= lvi_d;
			piv_q <= piv_d;
			pos_q <= pos_d;
			ioc_q <= ioc_d;
			hold_q <= hold_d;
			hold_full_q <= hold_full_d;
			last_q <= last_d;
			desc_req <= desc_req_d;
			mem_req <= mem_req_d;
			chan_irq <= chan_irq_d;
			digital_out_slot_a <= slots_d[7:4];
			digital_out_slot_b <= slots_d[3:0];
		end
	end

	// descriptor entries are eight bytes, so the index lands at bit 3
	assign desc_offset = {civ_q, adcc_pkg::DESC_SHIFT_PAD};
	assign mem_wdata = {hold_q, 12'h000};

	// ---- global control and status, kept apart so a hot return spares the status and control bits 6:0
	always_comb
	begin
		gctl_d = gctl_q;
		gsta_d = gsta_q;
		if (io_wr && hit(io_addr, adcc_pkg::ADDR_GLOBAL_CONTROL))
			for (int b = 0; b < 4; b++)
				if (io_be[b])
					gctl_d[8*b +: 8] = io_wdata[8*b +: 8] & adcc_pkg::GCTL_WRITE_MASK[8*b +: 8];
		// warm reset may only start from a stopped clock, and ends once the clock is back
		gctl_d.warm_reset = (gctl_q.warm_reset & ~pin_rise[0])
			| (gctl_d.warm_reset & ~gctl_q.warm_reset & clock_stopped);
		if (io_wr && hit(io_addr, adcc_pkg::ADDR_GLOBAL_STATUS))
			for (int b = 0; b < 4; b++)
				if (io_be[b])
					gsta_d[8*b +: 8] = gsta_q[8*b +: 8] & ~io_wdata[8*b +: 8];
		if (rx_done && rx_word[0])
			gsta_d[adcc_pkg::GSTA_GPI_CHANGE] = 1'b1;
		if (clock_stopped)
		begin
			gsta_d[adcc_pkg::GSTA_RESUME_0] = gsta_d[adcc_pkg::GSTA_RESUME_0] | pin_rise[1];
			gsta_d[adcc_pkg::GSTA_RESUME_1] = gsta_d[adcc_pkg::GSTA_RESUME_1] | pin_rise[2];
			gsta_d[adcc_pkg::GSTA_RESUME_2] = gsta_d[adcc_pkg::GSTA_RESUME_2] | pin_rise[3];
		end
		gsta_d[adcc_pkg::GSTA_CLOCK_STOPPED] = clock_stopped;
		global_irq_d = (gsta_q[adcc_pkg::GSTA_GPI_CHANGE] & gctl_q.gpin_change_irq_enable)
			| |({gsta_q[adcc_pkg::GSTA_RESUME_2], gsta_q[adcc_pkg::GSTA_RESUME_1],
			gsta_q[adcc_pkg::GSTA_RESUME_0]} & gctl_q.resume_irq_enable);
		rdata_d = 32'h0;
		if (io_rd)
		begin
			if (hit(io_addr, adcc_pkg::ADDR_INDEX_WORD))
				rdata_d = {11'h000, stat_q, 3'h0, lvi_q, 3'h0, civ_q};
			else if (hit(io_addr, adcc_pkg::ADDR_POSITION_WORD))
				rdata_d = {ctl_q, 3'h0, piv_q, pos_q};
			else if (hit(io_addr, adcc_pkg::ADDR_GLOBAL_CONTROL))
				rdata_d = gctl_q;
			else if (hit(io_addr, adcc_pkg::ADDR_GLOBAL_STATUS))
				rdata_d = gsta_q;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			gctl_q <= adcc_pkg::GCTL_RESET;
			gsta_q <= 32'h0000_0000;
			global_irq <= 1'b0;
		end
		else if (hot_return_rst)
		begin
			gctl_q <= adcc_pkg::GCTL_RESET | 32'(gctl_d[6:0]);
			gsta_q <= gsta_d;
			global_irq <= global_irq_d;
		end
		else
		begin
			gctl_q <= gctl_d;
			gsta_q <= gsta_d;
			global_irq <= global_irq_d;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			io_rdata <= 32'h0000_0000;
			mem_write <= 1'b0;
			output_sample_width <= 2'h0;
			output_channel_count <= 2'h0;
		end
		else
		begin
			io_rdata <= rdata_d;
			mem_write <= ~channel_is_transmit;
			output_sample_width <= gctl_q.output_sample_width;
			output_channel_count <= gctl_q.output_channel_count;
		end
	end
endmodule : adcc_channel_control
`default_nettype wire

// [testbench/adcc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [7:0] io_addr,
	input wire logic [3:0] io_be,
	input wire logic io_wr,
	input wire logic [31:0] io_wdata,
	// fetch and memory
	input wire logic desc_req,
	input wire logic desc_ack,
	input wire logic [7:0] desc_offset,
	input wire logic mem_req,
	input wire logic mem_ack,
	// link and modes
	input wire logic link_sync,
	input wire logic link_sdata_out,
	input wire logic link_reset_n,
	input wire logic link_outputs_oe,
	input wire logic [3:0] digital_out_slot_a,
	input wire logic [3:0] digital_out_slot_b,
	input wire logic [1:0] output_sample_width,
	input wire logic [1:0] output_channel_count
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	logic gwr;
	assign gwr = io_wr && (io_addr[7:2] == 6'h0B);

	property p_link_off_low;
		!link_outputs_oe |-> !link_sync && !link_sdata_out && !link_reset_n;
	endproperty
	a_link_off_low: assert property (p_link_off_low)
		else $error("link pins not low while shut off");
	property p_slot_pair;
		{digital_out_slot_a, digital_out_slot_b} inside {8'h00, 8'h78, 8'h69, 8'hAB};
	endproperty
	a_slot_pair: assert property (p_slot_pair)
		else $error("slot pair not a legal choice");
	property p_width;
		gwr && io_be[2] |-> ##2 output_sample_width == $past(io_wdata[23:22], 2);
	endproperty
	a_width: assert property (p_width)
		else $error("sample width does not follow control");
	property p_count;
		gwr && io_be[2] |-> ##2 output_channel_count == $past(io_wdata[21:20], 2);
	endproperty
	a_count: assert property (p_count)
		else $error("channel count does not follow control");
	property p_cold;
		gwr && io_be[0] |-> ##2 link_reset_n == $past(io_wdata[1] && !io_wdata[3], 2);
	endproperty
	a_cold: assert property (p_cold)
		else $error("link reset does not follow control");
	property p_desc_hold;
		desc_req && !desc_ack |=> desc_req;
	endproperty
	a_desc_hold: assert property (p_desc_hold)
		else $error("descriptor request dropped before answer");
	property p_mem_hold;
		mem_req && !mem_ack |=> mem_req;
	endproperty
	a_mem_hold: assert property (p_mem_hold)
		else $error("memory request dropped before answer");
	property p_desc_align;
		desc_req |-> desc_offset[2:0] == 3'h0 ##1 desc_offset[2:0] == 3'h0;
	endproperty
	a_desc_align: assert property (p_desc_align)
		else $error("descriptor offset not eight-byte aligned");
endmodule : adcc_checker
`default_nettype wire

// [testbench/adcc_codec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_codec_model (
	// link from the controller
	input wire logic link_reset_n,
	input wire logic link_sync,
	// bench commands
	input wire logic suspend,
	input wire logic [2:0] wake,
	// codec side
	output logic bit_clk,
	output wire logic [2:0] sdin
);
	logic awake;
	initial
	begin
		awake = 1'b0;
		bit_clk = 1'b0;
		#13;
		forever
		begin
			#400;
			// the clock stands still while held in cold reset or asleep
			bit_clk = (awake && link_reset_n) ? ~bit_clk : 1'b0;
		end
	end
	always @(posedge link_reset_n) awake = 1'b1;
	always @(posedge suspend) awake = 1'b0;
	// a warm reset pulse wakes a sleeping codec
	always @(posedge link_sync) if (link_reset_n) awake = 1'b1;
	// an asleep codec signals resume by raising its line
	assign sdin = awake ? 3'b000 : wake;
endmodule : adcc_codec_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, rst, hot_return_rst, io_wr, io_rd, channel_is_transmit, desc_req, desc_ack;
	logic descriptor_completion_flag, mem_req, mem_write, mem_ack, bit_clk, suspend;
	logic link_sync, link_sdata_out, link_reset_n, link_outputs_oe, chan_irq, global_irq;
	wire serial_in_line_0, serial_in_line_1, serial_in_line_2;
	logic [2:0] wake;
	logic [7:0] io_addr, desc_offset;
	logic [3:0] io_be, digital_out_slot_a, digital_out_slot_b;
	logic [31:0] io_wdata, io_rdata, mem_wdata, mem_rdata;
	logic [15:0] desc_len;
	logic [1:0] output_sample_width, output_channel_count;
	logic [31:0] gval [3] = '{32'h4050_0073, 32'h80A0_0073, 32'hC000_0073};
	int fails, tests_run, cycles;

	adcc_channel_control uut (.clock, .rst, .hot_return_rst, .io_addr, .io_be, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .channel_is_transmit, .desc_req, .desc_offset, .desc_ack, .desc_len,
		.descriptor_completion_flag, .mem_req, .mem_write, .mem_wdata, .mem_ack, .mem_rdata,
		.bit_clk, .serial_in_line_0, .serial_in_line_1, .serial_in_line_2, .link_sync,
		.link_sdata_out, .link_reset_n, .link_outputs_oe, .chan_irq, .global_irq,
		.digital_out_slot_a, .digital_out_slot_b, .output_sample_width, .output_channel_count);
	adcc_codec_model codec (.link_reset_n, .link_sync, .suspend, .wake, .bit_clk,
		.sdin({serial_in_line_2, serial_in_line_1, serial_in_line_0}));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// memory side answers every request one cycle later
	always @(posedge clock)
	begin
		desc_ack <= desc_req && !desc_ack && !rst;
		mem_ack <= mem_req && !mem_ack && !rst;
		cycles++;
		if (cycles == 90000)
		begin
			fails++;
			$display("ERROR at %0t: timeout", $time);
			complete_run;
		end
	end

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
		@(posedge clock);
		io_addr <= a;
		io_be <= be;
		io_wdata <= v;
		io_wr <= 1'b1;
		@(posedge clock);
		io_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clock);
		io_rd <= 1'b0;
		#1 v = io_rdata;
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v & m, e);
	endtask : rdc
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask : idle
	task automatic wait_halt;
		int n;
		logic [31:0] v;
		n = 0;
		v = 32'h0;
		while (v[16] !== 1'b1 && n < 300)
		begin
			idle(50);
			rd(8'h04, v);
			n++;
		end
	endtask : wait_halt
	task automatic complete_run;
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		{rst, hot_return_rst, io_wr, io_rd, io_addr, io_be, io_wdata} = '0;
		rst = 1'b1;
		{suspend, wake, cycles, fails, tests_run} = '0;
		channel_is_transmit = 1'b1;
		descriptor_completion_flag = 1'b1;
		desc_len = 16'h0003;
		mem_rdata = 32'hABCDE000;
		idle(16);
		rst <= 1'b0;
		rdc(8'h04, 32'hFFFFFFFF, 32'h0001_0000);
		rdc(8'h08, 32'hFFFFFFFF, 32'h0);
		rdc(8'h2C, 32'hFFFFFFFF, 32'h0);
		rdc(8'h50, 32'hFFFFFFFF, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h2C, 4'hF, gval[i]);
			rdc(8'h2C, 32'hFFFFFFFF, gval[i]);
			chk(32'({output_sample_width, output_channel_count, digital_out_slot_a}), 32'({gval[i][23:20], 4'h0}));
		end
		@(posedge clock) hot_return_rst <= 1'b1;
		idle(4);
		hot_return_rst <= 1'b0;
		rdc(8'h2C, 32'hFFFFFFFF, 32'h73);
		idle(40);
		rdc(8'h30, 32'h0800_0000, 32'h0);
		wr(8'h2C, 4'h1, 32'h77);
		rdc(8'h2C, 32'hFFFFFFFF, 32'h73);
		suspend <= 1'b1;
		idle(20);
		rdc(8'h30, 32'h0800_0000, 32'h0800_0000);
		wr(8'h2C, 4'h1, 32'h77);
		rdc(8'h2C, 32'hFFFFFFFF, 32'h77);
		suspend <= 1'b0;
		idle(60);
		rdc(8'h2C, 32'hFFFFFFFF, 32'h73);
		// one flagged buffer, last index left at zero
		wr(8'h2C, 4'hF, 32'hC000_0073);
		wr(8'h08, 4'h8, 32'h1D00_0000);
		rdc(8'h04, 32'h0001_0000, 32'h0);
		chk(32'({digital_out_slot_a, digital_out_slot_b}), 32'hAB);
		wait_halt;
		rdc(8'h04, 32'h001F_001F, 32'h000F_0000);
		rdc(8'h08, 32'h001F_FFFF, 32'h0);
		chk(32'(chan_irq), 32'h1);
		wr(8'h04, 4'h4, 32'h001C_0000);
		rdc(8'h04, 32'h001F_0000, 32'h0003_0000);
		chk(32'(chan_irq), 32'h0);
		// second buffer has no completion flag
		descriptor_completion_flag <= 1'b0;
		desc_len <= 16'h0002;
		wr(8'h04, 4'h2, 32'h0000_0100);
		rdc(8'h04, 32'h0002_0000, 32'h0);
		wait_halt;
		rdc(8'h04, 32'h001F_1F1F, 32'h0007_0101);
		rdc(8'h08, 32'h001F_0000, 32'h0001_0000);
		// channel reset only after pausing
		wr(8'h08, 4'h8, 32'h1C00_0000);
		wr(8'h08, 4'h8, 32'h1E00_0000);
		rdc(8'h08, 32'hFFFFFFFF, 32'h1C00_0000);
		rdc(8'h04, 32'hFFFFFFFF, 32'h0001_0000);
		// resume on line 0 enabled, line 2 not
		wr(8'h30, 4'hF, 32'h2000_0C01);
		wr(8'h2C, 4'h1, 32'h12);
		suspend <= 1'b1;
		idle(20);
		wake <= 3'b101;
		idle(10);
		wake <= 3'b000;
		rdc(8'h30, 32'h2000_0C00, 32'h2000_0400);
		chk(32'(global_irq), 32'h1);
		wr(8'h30, 4'hF, 32'h0000_0400);
		idle(3);
		chk(32'(global_irq), 32'h0);
		wr(8'h2C, 4'h1, 32'h1A);
		idle(2);
		chk(32'({link_outputs_oe, link_reset_n, link_sync, link_sdata_out}), 32'h0);
		complete_run;
	end
endmodule : tb

bind adcc_channel_control adcc_checker u_chk (.clock, .rst, .io_addr, .io_be, .io_wr, .io_wdata,
	.desc_req, .desc_ack, .desc_offset, .mem_req, .mem_ack, .link_sync, .link_sdata_out,
	.link_reset_n, .link_outputs_oe, .digital_out_slot_a, .digital_out_slot_b,
	.output_sample_width, .output_channel_count);
`default_nettype wire
